// File: hdl/ofd_pkg.sv
// Shared constants and types for the operand field decoder
package ofd_pkg;

    localparam int BYTE_W  = 8;
    localparam int MAX_LEN = 6;
    localparam int LEN_W   = 3;
    localparam int CNT_W   = 2;
    localparam int ADDR_W  = 5;
    localparam int DATA_W  = 32;
    localparam int BE_W    = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] REG_FIELDS = 5'h08;
    localparam logic [ADDR_W-1:0] REG_OPER   = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_DISP   = 5'h10;
    localparam logic [ADDR_W-1:0] REG_IMM    = 5'h14;

    // Control register
    localparam int   CTRL_EN_BIT  = 0;
    localparam int   CTRL_ACK_BIT = 1;
    localparam logic CTRL_EN_RST  = 1'b1;

    // Status register
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_LEN_LSB  = 4;

    // Fields register
    localparam int FLD_OPC_LSB  = 0;
    localparam int FLD_DIR      = 6;
    localparam int FLD_SIZE     = 7;
    localparam int FLD_SEXT     = 8;
    localparam int FLD_CNT_CL   = 9;
    localparam int FLD_ZSET     = 10;
    localparam int FLD_MODE_LSB = 11;
    localparam int FLD_REG_LSB  = 13;
    localparam int FLD_RM_LSB   = 16;
    localparam int FLD_REG_EXT  = 19;
    localparam int FLD_REP      = 20;
    localparam int FLD_SHIFT    = 21;

    // Operand register
    localparam int OPR_REG_LSB  = 0;
    localparam int OPR_RM_LSB   = 4;
    localparam int OPR_RM_REG   = 8;
    localparam int OPR_BASE_LSB = 9;
    localparam int OPR_IDX_LSB  = 11;
    localparam int OPR_DIRECT   = 13;
    localparam int OPR_DISP_LSB = 14;
    localparam int OPR_IMM_LSB  = 16;
    localparam int OPR_REG_DST  = 18;

    // Byte positions inside the instruction
    localparam int POS_OPC   = 0;
    localparam int POS_MODRM = 1;
    localparam int POS_DISP  = 2;

    // Addressing form and register/memory codes
    localparam logic [1:0] MOD_MEM0  = 2'h0;
    localparam logic [1:0] MOD_MEM8  = 2'h1;
    localparam logic [1:0] MOD_MEM16 = 2'h2;
    localparam logic [1:0] MOD_REG   = 2'h3;
    localparam logic [2:0] RM_DIRECT = 3'h6;

    localparam logic [CNT_W-1:0] CNT_NONE = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 2'h1;
    localparam logic [CNT_W-1:0] CNT_TWO  = 2'h2;

    // First-byte classes handled by the length logic
    localparam logic [7:0] OPC_ALU_RM  = 8'b00???0??;
    localparam logic [7:0] OPC_IMM_GRP = 8'b100000??;
    localparam logic [7:0] OPC_MOV_RM  = 8'b100010??;
    localparam logic [7:0] OPC_MOV_IMM = 8'b1100011?;
    localparam logic [7:0] OPC_SHIFT   = 8'b110100??;
    localparam logic [7:0] OPC_REP     = 8'b1111001?;

    typedef enum logic [3:0] {
        ACC_LOW_BYTE, COUNT_LOW_BYTE, DATA_LOW_BYTE, BASE_LOW_BYTE,
        ACC_HIGH_BYTE, COUNT_HIGH_BYTE, DATA_HIGH_BYTE, BASE_HIGH_BYTE,
        ACCUMULATOR_WORD, COUNT_WORD, DATA_WORD, BASE_WORD,
        STACK_POINTER_WORD, FRAME_BASE_WORD, SOURCE_INDEX_WORD, DEST_INDEX_WORD
    } ofd_reg_e;

    typedef enum logic [1:0] {EA_NO_BASE, EA_BASE_WORD, EA_FRAME_WORD} ofd_base_e;
    typedef enum logic [1:0] {EA_NO_INDEX, EA_SOURCE_INDEX, EA_DEST_INDEX} ofd_index_e;
    typedef enum logic [2:0] {ST_OP, ST_CLS, ST_MODRM, ST_REST, ST_DONE} ofd_state_e;

endpackage : ofd_pkg

// File: hdl/ofd_dec_if.sv
// Decoded instruction fields passed between decoder modules
`timescale 1ns/1ps
interface ofd_dec_if;
    logic [7:0]               opByte;
    logic [7:0]               modByte;
    logic [5:0]               opcode;
    logic                     dirBit;
    logic                     sizeBit;
    logic                     sextBit;
    logic                     countBit;
    logic                     zBit;
    logic [1:0]               mode;
    logic [2:0]               regField;
    logic [2:0]               rmField;
    logic                     hasModrm;
    logic                     regIsExt;
    logic                     isShift;
    logic                     isRep;
    logic                     sextImm;
    logic [1:0]               immBytes;
    logic [1:0]               dispBytes;
    logic [2:0]               instrLen;
    ofd_pkg::ofd_reg_e        regOperand;
    ofd_pkg::ofd_reg_e        rmOperand;
    logic                     rmIsReg;
    ofd_pkg::ofd_base_e       eaBase;
    ofd_pkg::ofd_index_e      eaIndex;
    logic                     eaDirect;

    modport top (output opByte, modByte,
                 input opcode, dirBit, sizeBit, sextBit, countBit, zBit, mode,
                 regField, rmField, hasModrm, regIsExt, isShift, isRep, sextImm,
                 immBytes, dispBytes, instrLen, regOperand, rmOperand, rmIsReg,
                 eaBase, eaIndex, eaDirect);
    modport field (input opByte, modByte,
                   output opcode, dirBit, sizeBit, sextBit, countBit, zBit, mode,
                   regField, rmField, hasModrm, regIsExt, isShift, isRep, sextImm,
                   immBytes, dispBytes, instrLen);
    modport oper (input sizeBit, mode, regField, rmField,
                  output regOperand, rmOperand, rmIsReg, eaBase, eaIndex, eaDirect);
endinterface : ofd_dec_if

// File: hdl/ofd_field_dec.sv
// Field split, class and length decode of the leading two bytes
`timescale 1ns/1ps
module ofd_field_dec (
    ofd_dec_if.field dec
);
    logic [ofd_pkg::CNT_W-1:0] dispCnt;
    logic                      modrmNeeded;
    logic                      extSel;
    logic                      shiftSel;
    logic                      repSel;
    logic                      signExt;
    logic [ofd_pkg::CNT_W-1:0] immCnt;

    assign dec.opcode   = dec.opByte[7:2];                        // [RQ2]
    assign dec.dirBit   = dec.opByte[1];                          // [RQ18]
    assign dec.sizeBit  = dec.opByte[0];                          // [RQ18]
    assign dec.sextBit  = dec.opByte[1];
    assign dec.countBit = dec.opByte[1];
    assign dec.zBit     = dec.opByte[0];
    assign dec.mode     = dec.modByte[7:6];                       // [RQ18]
    assign dec.regField = dec.modByte[5:3];                       // [RQ18]
    assign dec.rmField  = dec.modByte[2:0];                       // [RQ18]

    always_comb begin
        modrmNeeded = 1'b0;
        extSel      = 1'b0;
        shiftSel    = 1'b0;
        repSel      = 1'b0;
        signExt     = 1'b0;
        immCnt      = ofd_pkg::CNT_NONE;
        casez (dec.opByte)
            ofd_pkg::OPC_ALU_RM, ofd_pkg::OPC_MOV_RM: begin
                modrmNeeded = 1'b1;
            end
            ofd_pkg::OPC_IMM_GRP: begin
                modrmNeeded = 1'b1;
                extSel      = 1'b1;                               // [RQ12]
                signExt     = dec.sextBit & dec.sizeBit;          // [RQ5]
                immCnt      = (dec.sizeBit && !dec.sextBit) ? ofd_pkg::CNT_TWO
                                                            : ofd_pkg::CNT_ONE;
            end
            ofd_pkg::OPC_MOV_IMM: begin
                modrmNeeded = 1'b1;
                extSel      = 1'b1;                               // [RQ12]
                immCnt      = dec.sizeBit ? ofd_pkg::CNT_TWO : ofd_pkg::CNT_ONE;
            end
            ofd_pkg::OPC_SHIFT: begin
                modrmNeeded = 1'b1;
                extSel      = 1'b1;
                shiftSel    = 1'b1;                               // [RQ6]
            end
            ofd_pkg::OPC_REP: begin
                repSel      = 1'b1;                               // [RQ7]
            end
            default: begin
                modrmNeeded = 1'b0;
            end
        endcase
    end

    always_comb begin
        if (dec.mode == ofd_pkg::MOD_MEM8) begin
            dispCnt = ofd_pkg::CNT_ONE;                           // [RQ8]
        end else if (dec.mode == ofd_pkg::MOD_MEM16) begin
            dispCnt = ofd_pkg::CNT_TWO;                           // [RQ8]
        end else if (dec.mode == ofd_pkg::MOD_MEM0 && dec.rmField == ofd_pkg::RM_DIRECT) begin
            dispCnt = ofd_pkg::CNT_TWO;                           // [RQ9]
        end else begin
            dispCnt = ofd_pkg::CNT_NONE;                          // [RQ8]
        end
    end

    assign dec.hasModrm  = modrmNeeded;
    assign dec.regIsExt  = extSel;
    assign dec.isShift   = shiftSel;
    assign dec.isRep     = repSel;
    assign dec.sextImm   = signExt;
    assign dec.immBytes  = immCnt;
    assign dec.dispBytes = modrmNeeded ? dispCnt : ofd_pkg::CNT_NONE;
    assign dec.instrLen  = ofd_pkg::LEN_W'(1) + ofd_pkg::LEN_W'(modrmNeeded)
                         + ofd_pkg::LEN_W'(dec.dispBytes)
                         + ofd_pkg::LEN_W'(immCnt);               // [RQ19] [RQ1]
endmodule : ofd_field_dec

// File: hdl/ofd_operand_sel.sv
// Register operand selection and effective address recipe
`timescale 1ns/1ps
module ofd_operand_sel (
    ofd_dec_if.oper dec
);
    function automatic ofd_pkg::ofd_reg_e regOf(input logic size, input logic [2:0] code);
        regOf = ofd_pkg::ofd_reg_e'({size, code});                // [RQ4] [RQ11]
    endfunction : regOf

    logic memDirect;

    assign dec.regOperand = regOf(dec.sizeBit, dec.regField);
    assign dec.rmOperand  = regOf(dec.sizeBit, dec.rmField);      // [RQ10]
    assign dec.rmIsReg    = (dec.mode == ofd_pkg::MOD_REG);       // [RQ10]
    assign memDirect      = (dec.mode == ofd_pkg::MOD_MEM0)
                          && (dec.rmField == ofd_pkg::RM_DIRECT);
    assign dec.eaDirect   = memDirect;                            // [RQ9] [RQ14]

    always_comb begin
        dec.eaBase  = ofd_pkg::EA_NO_BASE;
        dec.eaIndex = ofd_pkg::EA_NO_INDEX;
        if (dec.mode != ofd_pkg::MOD_REG && !memDirect) begin
            case (dec.rmField)                                    // [RQ13]
                3'h0: begin
                    dec.eaBase  = ofd_pkg::EA_BASE_WORD;
                    dec.eaIndex = ofd_pkg::EA_SOURCE_INDEX;
                end
                3'h1: begin
                    dec.eaBase  = ofd_pkg::EA_BASE_WORD;
                    dec.eaIndex = ofd_pkg::EA_DEST_INDEX;
                end
                3'h2: begin
                    dec.eaBase  = ofd_pkg::EA_FRAME_WORD;
                    dec.eaIndex = ofd_pkg::EA_SOURCE_INDEX;
                end
                3'h3: begin
                    dec.eaBase  = ofd_pkg::EA_FRAME_WORD;
                    dec.eaIndex = ofd_pkg::EA_DEST_INDEX;
                end
                3'h4: begin
                    dec.eaIndex = ofd_pkg::EA_SOURCE_INDEX;
                end
                3'h5: begin
                    dec.eaIndex = ofd_pkg::EA_DEST_INDEX;
                end
                3'h6: begin
                    dec.eaBase  = ofd_pkg::EA_FRAME_WORD;         // [RQ14]
                end
                default: begin
                    dec.eaBase  = ofd_pkg::EA_BASE_WORD;
                end
            endcase
        end
    end
endmodule : ofd_operand_sel

// File: hdl/ofd_decoder.sv
// Instruction leading-byte decoder with Avalon-MM register access
// Overview of operation
// [RQ1] Instructions span one to six bytes
// [RQ2] First byte's upper six bits are opcode
// [RQ3] Direction 1: selector operand is destination
// [RQ4] Size bit: 0 byte, 1 word
// [RQ5] Extend and word: sign-extend 8-bit immediate
// [RQ6] Count bit: 0 one, 1 count register
// [RQ7] Loop bit: 1 while zero set
// [RQ8] Addressing form selects displacement size or register
// [RQ9] Form 00 code 110: direct 16-bit address
// [RQ10] Register form: second field names register
// [RQ11] Eight register codes, size dependent
// [RQ12] Selector field may extend the opcode
// [RQ13] Memory codes map to base/index combinations
// [RQ14] Displacement forms add displacement; 110 frame
// [RQ15] Two-byte displacement is low then high
// [RQ16] One-byte displacement sign-extends to sixteen bits
// [RQ17] Immediate follows displacement, high byte second
// [RQ18] Fixed bit positions in first two bytes
// [RQ19] Report total instruction length
`timescale 1ns/1ps
module ofd_decoder (
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire logic [ofd_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [ofd_pkg::DATA_W-1:0]  avs_writedata,
    input  wire logic [ofd_pkg::BE_W-1:0]    avs_byteenable,
    output logic      [ofd_pkg::DATA_W-1:0]  avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic [ofd_pkg::BYTE_W-1:0]  fetchByte,
    input  wire logic                        fetchValid,
    output logic                             fetchReady,
    output logic                             decodeDone,
    output logic      [ofd_pkg::LEN_W-1:0]   instrLength
);
    ofd_dec_if dec ();

    ofd_field_dec u_field (
        .dec (dec.field)
    );

    ofd_operand_sel u_oper (
        .dec (dec.oper)
    );

    logic [ofd_pkg::BYTE_W-1:0]  instrBuf [ofd_pkg::MAX_LEN];
    ofd_pkg::ofd_state_e         state_r;
    ofd_pkg::ofd_state_e         state_nxt;
    logic [ofd_pkg::LEN_W-1:0]   count_r;
    logic [ofd_pkg::LEN_W-1:0]   count_nxt;
    logic                        enable_r;
    logic                        waitReq_r;
    logic [ofd_pkg::DATA_W-1:0]  readData_r;
    logic                        fetchReady_r;
    logic                        fetchReady_nxt;
    logic                        done_r;
    logic [ofd_pkg::LEN_W-1:0]   len_r;
    logic [ofd_pkg::DATA_W-1:0]  fields_r;
    logic [ofd_pkg::DATA_W-1:0]  oper_r;
    logic [15:0]                 disp_r;
    logic [15:0]                 imm_r;

    wire                         accept;
    wire                         busDone;
    wire                         ctrlWrite;
    wire                         ackWrite;
    wire                         finish;
    wire [ofd_pkg::LEN_W-1:0]    immPos;
    wire [ofd_pkg::BYTE_W-1:0]   dispLo;
    wire [ofd_pkg::BYTE_W-1:0]   dispHi;
    wire [ofd_pkg::BYTE_W-1:0]   immLo;
    wire [ofd_pkg::BYTE_W-1:0]   immHi;
    wire [15:0]                  dispVal;
    wire [15:0]                  immVal;
    logic [ofd_pkg::DATA_W-1:0]  fieldsVal;
    logic [ofd_pkg::DATA_W-1:0]  operVal;
    wire [ofd_pkg::DATA_W-1:0]   readMux;

    function automatic logic [ofd_pkg::BYTE_W-1:0] pickByte(input logic [ofd_pkg::LEN_W-1:0] idx);
        pickByte = (int'(idx) < ofd_pkg::MAX_LEN) ? instrBuf[idx] : 8'h00;
    endfunction : pickByte

    // Byte collection
    assign accept    = fetchValid && fetchReady_r;
    assign dec.opByte  = instrBuf[ofd_pkg::POS_OPC];
    assign dec.modByte = instrBuf[ofd_pkg::POS_MODRM];
    assign finish    = (state_r == ofd_pkg::ST_CLS && !dec.hasModrm)
                    || (state_r == ofd_pkg::ST_REST && count_r == dec.instrLen);   // [RQ19]

    // Bus handshake
    assign busDone   = (avs_read || avs_write) && !waitReq_r;
    assign ctrlWrite = avs_write && !waitReq_r && (avs_address == ofd_pkg::REG_CTRL)
                     && avs_byteenable[0];
    assign ackWrite  = ctrlWrite && avs_writedata[ofd_pkg::CTRL_ACK_BIT];

    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        case (state_r)
            ofd_pkg::ST_OP: begin
                if (accept) begin
                    state_nxt = ofd_pkg::ST_CLS;
                    count_nxt = ofd_pkg::LEN_W'(1);
                end
            end
            ofd_pkg::ST_CLS: begin
                state_nxt = dec.hasModrm ? ofd_pkg::ST_MODRM : ofd_pkg::ST_DONE;
            end
            ofd_pkg::ST_MODRM: begin
                if (accept) begin
                    state_nxt = ofd_pkg::ST_REST;
                    count_nxt = count_r + ofd_pkg::LEN_W'(1);
                end
            end
            ofd_pkg::ST_REST: begin
                if (finish) begin
                    state_nxt = ofd_pkg::ST_DONE;
                end else if (accept) begin
                    count_nxt = count_r + ofd_pkg::LEN_W'(1);    // [RQ1]
                end
            end
            default: begin
                if (ackWrite) begin
                    state_nxt = ofd_pkg::ST_OP;
                    count_nxt = '0;
                end
            end
        endcase
    end

    assign fetchReady_nxt = enable_r && ((state_nxt == ofd_pkg::ST_OP)
                          || (state_nxt == ofd_pkg::ST_MODRM)
                          || (state_nxt == ofd_pkg::ST_REST && state_r == ofd_pkg::ST_REST
                              && count_nxt < dec.instrLen));

    // Displacement and immediate assembly
    assign dispLo  = pickByte(ofd_pkg::LEN_W'(ofd_pkg::POS_DISP));
    assign dispHi  = pickByte(ofd_pkg::LEN_W'(ofd_pkg::POS_DISP + 1));
    assign dispVal = (dec.dispBytes == ofd_pkg::CNT_TWO) ? {dispHi, dispLo}           // [RQ15]
                   : (dec.dispBytes == ofd_pkg::CNT_ONE) ? {{8{dispLo[7]}}, dispLo}   // [RQ16]
                   : 16'h0000;
    assign immPos  = ofd_pkg::LEN_W'(ofd_pkg::POS_DISP) + ofd_pkg::LEN_W'(dec.dispBytes); // [RQ17]
    assign immLo   = pickByte(immPos);
    assign immHi   = pickByte(immPos + ofd_pkg::LEN_W'(1));
    assign immVal  = (dec.immBytes == ofd_pkg::CNT_TWO) ? {immHi, immLo}              // [RQ17]
                   : (dec.immBytes == ofd_pkg::CNT_NONE) ? 16'h0000
                   : dec.sextImm ? {{8{immLo[7]}}, immLo}                             // [RQ5]
                   : {8'h00, immLo};

    always_comb begin
        fieldsVal = '0;
        fieldsVal[ofd_pkg::FLD_OPC_LSB +: 6]  = dec.opcode;                // [RQ2]
        fieldsVal[ofd_pkg::FLD_DIR]           = dec.dirBit;
        fieldsVal[ofd_pkg::FLD_SIZE]          = dec.sizeBit;               // [RQ4]
        fieldsVal[ofd_pkg::FLD_SEXT]          = dec.sextImm;               // [RQ5]
        fieldsVal[ofd_pkg::FLD_CNT_CL]        = dec.isShift && dec.countBit; // [RQ6]
        fieldsVal[ofd_pkg::FLD_ZSET]          = dec.isRep && dec.zBit;     // [RQ7]
        fieldsVal[ofd_pkg::FLD_MODE_LSB +: 2] = dec.mode;
        fieldsVal[ofd_pkg::FLD_REG_LSB +: 3]  = dec.regField;
        fieldsVal[ofd_pkg::FLD_RM_LSB +: 3]   = dec.rmField;
        fieldsVal[ofd_pkg::FLD_REG_EXT]       = dec.regIsExt;              // [RQ12]
        fieldsVal[ofd_pkg::FLD_REP]           = dec.isRep;
        fieldsVal[ofd_pkg::FLD_SHIFT]         = dec.isShift;
        if (!dec.hasModrm) begin
            fieldsVal[ofd_pkg::FLD_MODE_LSB +: 8] = '0;
        end
    end

    always_comb begin
        operVal = '0;
        if (dec.hasModrm) begin
            operVal[ofd_pkg::OPR_REG_LSB +: 4]  = dec.regIsExt ? 4'h0 : dec.regOperand; // [RQ12]
            operVal[ofd_pkg::OPR_RM_LSB +: 4]   = dec.rmIsReg ? dec.rmOperand : 4'h0;   // [RQ10]
            operVal[ofd_pkg::OPR_RM_REG]        = dec.rmIsReg;
            operVal[ofd_pkg::OPR_BASE_LSB +: 2] = dec.eaBase;                // [RQ13]
            operVal[ofd_pkg::OPR_IDX_LSB +: 2]  = dec.eaIndex;               // [RQ13]
            operVal[ofd_pkg::OPR_DIRECT]        = dec.eaDirect;              // [RQ9]
            operVal[ofd_pkg::OPR_DISP_LSB +: 2] = dec.dispBytes;             // [RQ8]
            operVal[ofd_pkg::OPR_REG_DST]       = dec.dirBit && !dec.regIsExt; // [RQ3]
        end
        operVal[ofd_pkg::OPR_IMM_LSB +: 2] = dec.immBytes;
    end

    // Register read selection
    assign readMux = (avs_address == ofd_pkg::REG_CTRL)   ? {31'h00000000, enable_r}
                   : (avs_address == ofd_pkg::REG_STATUS) ? (ofd_pkg::DATA_W'(done_r)
                        | (ofd_pkg::DATA_W'(len_r) << ofd_pkg::STAT_LEN_LSB))
                   : (avs_address == ofd_pkg::REG_FIELDS) ? fields_r
                   : (avs_address == ofd_pkg::REG_OPER)   ? oper_r
                   : (avs_address == ofd_pkg::REG_DISP)   ? {16'h0000, disp_r}
                   : (avs_address == ofd_pkg::REG_IMM)    ? {16'h0000, imm_r}
                   : 32'h00000000;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < ofd_pkg::MAX_LEN; i++) begin
                instrBuf[i] <= 8'h00;
            end
        end else if (accept) begin
            instrBuf[count_r] <= fetchByte;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r      <= ofd_pkg::ST_OP;
            count_r      <= '0;
            fetchReady_r <= 1'b0;
            done_r       <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            count_r      <= count_nxt;
            fetchReady_r <= fetchReady_nxt;
            done_r       <= (state_nxt == ofd_pkg::ST_DONE);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            len_r    <= '0;
            fields_r <= '0;
            oper_r   <= '0;
            disp_r   <= 16'h0000;
            imm_r    <= 16'h0000;
        end else if (finish) begin
            len_r    <= dec.instrLen;                                      // [RQ19]
            fields_r <= fieldsVal;
            oper_r   <= operVal;
            disp_r   <= dispVal;
            imm_r    <= immVal;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            enable_r   <= ofd_pkg::CTRL_EN_RST;
            waitReq_r  <= 1'b1;
            readData_r <= '0;
        end else begin
            waitReq_r  <= !((avs_read || avs_write) && waitReq_r);
            if ((avs_read || avs_write) && waitReq_r) begin
                readData_r <= avs_read ? readMux : 32'h00000000;
            end
            if (ctrlWrite) begin
                enable_r <= avs_writedata[ofd_pkg::CTRL_EN_BIT];
            end
        end
    end

    assign avs_readdata    = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign fetchReady      = fetchReady_r;
    assign decodeDone      = done_r;
    assign instrLength     = len_r;
endmodule : ofd_decoder

// File: dv/ofd_fetch_model.sv
// Prefetch byte source model
`timescale 1ns/1ps
module ofd_fetch_model (
    input  wire logic       clock, rstn, fetchReady,
    output logic            fetchValid,
    output logic [7:0]      fetchByte
);
    logic [7:0] q[$];
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fetchValid <= 1'h0;
        end else if (!fetchValid || fetchReady) begin
            fetchValid <= q.size() > 0;
            fetchByte  <= q.size() > 0 ? q.pop_front() : ~fetchByte;
        end
    end
endmodule : ofd_fetch_model

// File: dv/ofd_decoder_chk.sv
// Port assertions for the operand field decoder
`timescale 1ns/1ps
module ofd_decoder_chk (
    input wire logic        clock, rstn, avs_read, avs_write, avs_waitrequest,
    input wire logic        fetchValid, fetchReady, decodeDone,
    input wire logic [4:0]  avs_address,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [7:0]  fetchByte,
    input wire logic [2:0]  instrLength
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire take = fetchValid && fetchReady;
    wire ack  = avs_write && !avs_waitrequest && avs_address == 5'h00 && avs_writedata[1];
    len_ok_a: assert property (decodeDone |-> instrLength inside {[1:6]})
        else $error("len");
    stall_done_a: assert property (decodeDone |-> !fetchReady)
        else $error("stall");
    len_hold_a: assert property (decodeDone && !ack |=> decodeDone && $stable(instrLength))
        else $error("hold");
    done_late_a: assert property ($rose(decodeDone) |-> $past(take, 2))
        else $error("late");
    ack_clear_a: assert property (ack && avs_writedata[0] && decodeDone |=> !decodeDone && fetchReady)
        else $error("ack");
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait");
    wait_back_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("back");
    hole_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 5'h14 |-> avs_readdata == 32'h0)
        else $error("hole");
    cover property ($rose(decodeDone));
    cover property (ack);
    cover property (avs_read && !avs_waitrequest);
endmodule : ofd_decoder_chk
bind ofd_decoder ofd_decoder_chk ofd_decoder_chk_inst (.*);

// File: dv/ofd_decoder_test.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
module ofd_decoder_test;
    logic        clock = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic        fetchValid, fetchReady, avs_waitrequest, decodeDone;
    logic [4:0]  avs_address = 5'h00;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
    logic [7:0]  fetchByte;
    logic [2:0]  instrLength;
    int          num_errors = 0, samples_checked = 0;
    ofd_decoder ofd_decoder_inst (.*);
    ofd_fetch_model ofd_fetch_model_inst (.*);
    always #10 clock = ~clock;
    task chk(input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        {avs_write, avs_read} <= {w, !w};
        do @(posedge clock); while (avs_waitrequest !== 1'h0);
        r = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
        @(posedge clock);
    endtask : bus
    task dec(input logic [47:0] v, input int n, input logic [4:0] a, b,
             input logic [31:0] ea, eb);
        for (int i = 0; i < n; i++) ofd_fetch_model_inst.q.push_back(v[8*i+:8]);
        while (decodeDone !== 1'h1) @(posedge clock);
        chk(32'(instrLength), n);
        bus(1'h0, a, 32'h0);
        chk(r, ea);
        bus(1'h0, b, 32'h0);
        chk(r, eb);
        bus(1'h1, 5'h00, 32'h3);
    endtask : dec
    task t_sext;
        dec(48'hF0FE4683, 4, 5'h10, 5'h14, 32'hFFFE, 32'hFFF0);
    endtask : t_sext
    task t_direct;
        dec(48'h12341E8B, 4, 5'h10, 5'h0C, 32'h1234, 32'h4A00B);
    endtask : t_direct
    task t_long;
        dec(48'h5678123486C7, 6, 5'h10, 5'h14, 32'h1234, 32'h5678);
    endtask : t_long
    task t_regform;
        dec(48'hC38A, 2, 5'h18, 5'h0C, 32'h0, 32'h40130);
    endtask : t_regform
    task t_rep;
        dec(48'hF3, 1, 5'h04, 5'h08, 32'h11, 32'h1004FC);
    endtask : t_rep
    task t_shift;
        dec(48'hE0D3, 2, 5'h08, 5'h0C, 32'h289AF4, 32'h180);
    endtask : t_shift
    task t_index;
        dec(48'h804101, 3, 5'h10, 5'h0C, 32'hFF80, 32'h5208);
    endtask : t_index
    task report_and_stop;
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #20us;
        num_errors++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'h1;
        @(posedge clock);
        t_sext;
        t_direct;
        t_long;
        t_regform;
        t_rep;
        t_shift;
        t_index;
        report_and_stop;
    end
endmodule : ofd_decoder_test
